// ### shared/rx_irq_pkg.sv
// Purpose: shared constants and types of the receive interrupt control block
// Assumes: 16-bit register port, byte offsets on an 8-bit address
// Notes: offsets of the select and event registers are local choices
`default_nettype none
package rx_irq_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_EVT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;

    // ==========================================================
    // field positions
    localparam int POS_TC_SEL = 0;
    localparam int POS_WORD = 3;
    localparam int POS_TSA_SEL = 8;
    localparam int POS_HI_LSB = 8;
    localparam int POS_SLOT_LSB = 9;
    localparam int POS_COUNT_LSB = 9;
    localparam int POS_DELAY_LSB = 13;
    localparam int POS_CMD_LSB = 12;
    localparam int SLOT_NUM_W = 7;
    localparam int DELAY_W = 3;
    localparam int COUNT_W = 4;
    localparam int CMD_W = 4;
    // arm bits 7,6,5,4,2,1; bits 3 and 0 are selects
    localparam logic [7:0] ARM_BITS = 8'hF6;

    // ==========================================================
    // reset values and codes
    localparam logic [7:0] LOW_RST = 8'h00;
    localparam logic [7:0] THR_RST = 8'h00;
    localparam logic [15:0] TC_RST = 16'h0000;
    localparam logic [3:0] CMD_SLOT = 4'h4;
    localparam logic [3:0] CMD_FILL = 4'h5;
    localparam logic [3:0] CMD_IRQ_THR = 4'h6;
    localparam logic [3:0] CMD_DMA_THR = 4'h7;

    // ==========================================================
    // interrupt events
    localparam int EV_STAT = 0;
    localparam int EV_DATA = 1;
    localparam int EV_DMA = 2;
    localparam int EV_NUM = 3;

    typedef enum logic [3:0] {
        VIEW_FILL = 4'b0001,
        VIEW_SLOT = 4'b0010,
        VIEW_IRQ = 4'b0100,
        VIEW_DMA = 4'b1000
    } view_t;

    typedef struct packed {
        logic [6:0] number;
        logic [2:0] bit_delay;
        logic [3:0] count;
    } slot_cfg_t;

    localparam slot_cfg_t SLOT_RST = '0;

endpackage
`default_nettype wire

// ### src/level_compare.sv
// Purpose: registered fill-level against threshold comparison
// Assumes: level and threshold come from logic on the same clock
// Notes: request is strictly above the threshold
`timescale 1ns/1ns
`default_nettype none
module level_compare #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // compare inputs
    input wire logic [W-1:0] level,
    input wire logic [W-1:0] thr,
    // results
    output logic req,
    output logic rise
);

    logic req_r;
    logic rise_r;
    logic above;

    assign above = level > thr;

    // ==========================================================
    // request and its rising edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            req_r <= 1'b0;
            rise_r <= 1'b0;
        end
        else
        begin
            req_r <= above;
            rise_r <= above && !req_r;
        end
    end

    assign req = req_r;
    assign rise = rise_r;

endmodule
`default_nettype wire

// ### src/event_status.sv
// Purpose: sticky event status with mask and one level interrupt
// Assumes: a read strobe of the status register clears it
// Notes: an event in the clearing cycle survives the clear
`timescale 1ns/1ns
`default_nettype none
module event_status #(
    parameter int N = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events and software access
    input wire logic [N-1:0] set,
    input wire logic rd_clr,
    input wire logic mask_wr,
    input wire logic [N-1:0] mask_in,
    // state and interrupt
    output logic [N-1:0] status,
    output logic [N-1:0] mask,
    output logic irq
);

    logic [N-1:0] status_r;
    logic [N-1:0] mask_r;

    // ==========================================================
    // sticky bits, set wins over the read clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            status_r <= '0;
        else
            status_r <= (rd_clr ? '0 : status_r) | set;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mask_r <= '0;
        else if (mask_wr)
            mask_r <= mask_in;
    end

    assign status = status_r;
    assign mask = mask_r;
    assign irq = |(status_r & mask_r);

    property p_set_wins;
        @(posedge clk) disable iff (!rst_n)
        (rd_clr && |set) |=> ((status_r & $past(set)) == $past(set));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost in clearing cycle");

endmodule
`default_nettype wire

// ### src/rx_irq_ctrl_top.sv
// Purpose: receive interrupt control register with multiplexed upper byte
// Assumes: status flags, fill level and time constants come from this clock
// Notes: upper byte view follows the last select command written
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RQ1: in the slot view bits 15-9 are a readable, writable byte count from frame sync that starts reception.
// RQ2: in the offset/count view bits 15-13 are a write-only bit delay before reception starts.
// RQ3: a slot count of zero disables the slot assigner, else it gives consecutive slots per frame.
// RQ4: in the fill view, which holds after reset, the upper byte reads the receive queue fill level.
// RQ5: in the interrupt threshold view a data interrupt is requested while the fill exceeds it.
// RQ6: in the DMA threshold view a DMA request is raised while the fill exceeds it.
// RQ7: bit 7 arms the interrupt for leaving hunt, status bit 7.
// RQ8: bit 6 arms the interrupt for idle line received, status bit 6.
// RQ9: bit 5 arms the interrupt for break or abort, status bit 5.
// RQ10: bit 4 arms the interrupt for the receive boundary, status bit 4.
// RQ11: bit 2 arms the interrupt for abort or parity error, status bit 2.
// RQ12: bit 1 arms the interrupt for receiver overrun, status bit 1.
// RQ13: bit 3 makes queued status cover the two oldest characters instead of the oldest.
// RQ14: bit 0 makes time constant 0 reads return a captured count instead of the constant.
// RQ15: the upper view follows the last select command; in the slot view bit 8 picks number or offset/count.
// RQ16: a status interrupt request needs both the status flag and its arm bit.
module rx_irq_ctrl_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // receiver side
    input wire logic [7:0] RX_STATUS,
    input wire logic [7:0] FIFO_LEVEL,
    // baud rate generator 0
    input wire logic [15:0] TC0_VALUE,
    input wire logic [15:0] TC0_COUNT,
    input wire logic TC0_RD,
    output logic [15:0] TC0_RDATA,
    // requests and selects
    output logic STATUS_IRQ_REQ,
    output logic DATA_IRQ_REQ,
    output logic DMA_REQ,
    output logic TWO_CHAR_STATUS,
    output rx_irq_pkg::slot_cfg_t SLOT_CFG,
    output logic TSA_ENABLE,
    // interrupt
    output logic IRQ
);
    import rx_irq_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [3:0] view_code(input view_t v);
        case (v)
            VIEW_SLOT: view_code = CMD_SLOT;
            VIEW_IRQ: view_code = CMD_IRQ_THR;
            VIEW_DMA: view_code = CMD_DMA_THR;
            default: view_code = CMD_FILL;
        endcase
    endfunction

    // ==========================================================
    // state
    view_t view_r;
    view_t view_nxt;
    logic [7:0] low_r;
    slot_cfg_t slot_r;
    logic [7:0] irq_thr_r;
    logic [7:0] dma_thr_r;
    logic [15:0] rdata_r;
    logic [15:0] rd_val;
    logic [7:0] ctrl_hi;
    logic [15:0] tc0_r;
    logic status_req_r;
    logic status_rise_r;
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_mask;
    logic rd_evt;
    logic [3:0] cmd_in;
    logic data_rise;
    logic dma_rise;
    logic [EV_NUM-1:0] ev_set;
    logic [EV_NUM-1:0] ev_status;
    logic [EV_NUM-1:0] ev_mask;
    logic past_run_r;

    // ==========================================================
    // address decode
    assign wr_ctrl = WR && hit(ADDR, OFS_CTRL);
    assign wr_cmd = WR && hit(ADDR, OFS_CMD);
    assign wr_mask = WR && hit(ADDR, OFS_MASK);
    assign rd_evt = RD && hit(ADDR, OFS_EVT);
    assign cmd_in = WDATA[POS_CMD_LSB +: CMD_W];

    // ==========================================================
    // view select
    always_comb
    begin
        view_nxt = view_r;
        if (wr_cmd)
        begin
            case (cmd_in)
                CMD_SLOT: view_nxt = VIEW_SLOT; // RQ15
                CMD_FILL: view_nxt = VIEW_FILL; // RQ15
                CMD_IRQ_THR: view_nxt = VIEW_IRQ; // RQ15
                CMD_DMA_THR: view_nxt = VIEW_DMA; // RQ15
                default: view_nxt = view_r;
            endcase
        end
    end

    // fill view after reset
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            view_r <= VIEW_FILL; // RQ4
        else
            view_r <= view_nxt;
    end

    // ==========================================================
    // lower byte: arm bits and selects, writable in every view
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            low_r <= LOW_RST;
        else if (wr_ctrl)
            low_r <= WDATA[7:0]; // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12 RQ13 RQ14
    end

    // ==========================================================
    // slot assigner fields
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            slot_r <= SLOT_RST;
        else if (wr_ctrl && view_r == VIEW_SLOT)
        begin
            if (!WDATA[POS_TSA_SEL])
                slot_r.number <= WDATA[POS_SLOT_LSB +: SLOT_NUM_W]; // RQ1
            else
            begin
                slot_r.bit_delay <= WDATA[POS_DELAY_LSB +: DELAY_W]; // RQ2
                slot_r.count <= WDATA[POS_COUNT_LSB +: COUNT_W]; // RQ3
            end
        end
    end

    assign SLOT_CFG = slot_r;
    assign TSA_ENABLE = (slot_r.count != '0); // RQ3

    // ==========================================================
    // thresholds
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            irq_thr_r <= THR_RST;
        else if (wr_ctrl && view_r == VIEW_IRQ)
            irq_thr_r <= WDATA[POS_HI_LSB +: 8]; // RQ5
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            dma_thr_r <= THR_RST;
        else if (wr_ctrl && view_r == VIEW_DMA)
            dma_thr_r <= WDATA[POS_HI_LSB +: 8]; // RQ6
    end

    // thresholds keep working whichever view is selected
    level_compare #(.W(8)) u_data_cmp (
        .clk(CLK),
        .rst_n(RST_N),
        .level(FIFO_LEVEL),
        .thr(irq_thr_r),
        .req(DATA_IRQ_REQ),
        .rise(data_rise)
    ); // RQ5

    level_compare #(.W(8)) u_dma_cmp (
        .clk(CLK),
        .rst_n(RST_N),
        .level(FIFO_LEVEL),
        .thr(dma_thr_r),
        .req(DMA_REQ),
        .rise(dma_rise)
    ); // RQ6

    // ==========================================================
    // status interrupt request
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            status_req_r <= 1'b0;
            status_rise_r <= 1'b0;
        end
        else
        begin
            status_req_r <= |(RX_STATUS & low_r & ARM_BITS); // RQ16
            status_rise_r <= |(RX_STATUS & low_r & ARM_BITS) && !status_req_r;
        end
    end

    assign STATUS_IRQ_REQ = status_req_r;
    assign TWO_CHAR_STATUS = low_r[POS_WORD]; // RQ13

    // ==========================================================
    // time constant 0 read path
    // snapshot taken only on the read strobe so a running count reads stable
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            tc0_r <= TC_RST;
        else if (TC0_RD)
            tc0_r <= low_r[POS_TC_SEL] ? TC0_COUNT : TC0_VALUE; // RQ14
    end

    assign TC0_RDATA = tc0_r;

    // ==========================================================
    // event status and interrupt
    always_comb
    begin
        ev_set = '0;
        ev_set[EV_STAT] = status_rise_r;
        ev_set[EV_DATA] = data_rise;
        ev_set[EV_DMA] = dma_rise;
    end

    event_status #(.N(EV_NUM)) u_evt (
        .clk(CLK),
        .rst_n(RST_N),
        .set(ev_set),
        .rd_clr(rd_evt),
        .mask_wr(wr_mask),
        .mask_in(WDATA[EV_NUM-1:0]),
        .status(ev_status),
        .mask(ev_mask),
        .irq(IRQ)
    );

    // ==========================================================
    // read mux, data stand one cycle after the strobe only
    always_comb
    begin
        case (view_r)
            VIEW_SLOT: ctrl_hi = {slot_r.number, 1'b0}; // RQ1 RQ2
            VIEW_IRQ: ctrl_hi = irq_thr_r; // RQ5
            VIEW_DMA: ctrl_hi = dma_thr_r; // RQ6
            default: ctrl_hi = FIFO_LEVEL; // RQ4
        endcase
    end

    always_comb
    begin
        rd_val = 16'h0000;
        if (hit(ADDR, OFS_CTRL))
            rd_val = {ctrl_hi, low_r};
        else if (hit(ADDR, OFS_CMD))
            rd_val = {view_code(view_r), 12'h000};
        else if (hit(ADDR, OFS_EVT))
            rd_val = 16'(ev_status);
        else if (hit(ADDR, OFS_MASK))
            rd_val = 16'(ev_mask);
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            rdata_r <= 16'h0000;
        else
            rdata_r <= RD ? rd_val : 16'h0000;
    end

    assign RDATA = rdata_r;

    // ==========================================================
    // checks
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            past_run_r <= 1'b0;
        else
            past_run_r <= 1'b1;
    end

    property p_slot_num;
        @(posedge CLK) disable iff (!RST_N)
        (wr_ctrl && view_r == VIEW_SLOT && !WDATA[POS_TSA_SEL]) ##1 (RD && hit(ADDR, OFS_CTRL))
        |=> RDATA[15:9] == $past(WDATA[15:9], 2) && !RDATA[8];
    endproperty
    a_slot_num: assert property (p_slot_num) // RQ1
        else $error("slot number not read back");

    property p_delay;
        @(posedge CLK) disable iff (!RST_N)
        (wr_ctrl && view_r == VIEW_SLOT && WDATA[POS_TSA_SEL])
        |=> SLOT_CFG.bit_delay == $past(WDATA[15:13]) && $stable(SLOT_CFG.number);
    endproperty
    a_delay: assert property (p_delay) // RQ2
        else $error("bit delay write wrong");

    property p_count;
        @(posedge CLK) disable iff (!RST_N)
        (wr_ctrl && view_r == VIEW_SLOT && WDATA[POS_TSA_SEL])
        |=> TSA_ENABLE == ($past(WDATA[12:9]) != 4'h0);
    endproperty
    a_count: assert property (p_count) // RQ3
        else $error("slot count enable wrong");

    property p_fill;
        @(posedge CLK) disable iff (!RST_N)
        (RD && hit(ADDR, OFS_CTRL) && view_r == VIEW_FILL)
        |=> RDATA[15:8] == $past(FIFO_LEVEL);
    endproperty
    a_fill: assert property (p_fill) // RQ4
        else $error("fill level not shown");

    property p_data_req;
        @(posedge CLK) disable iff (!RST_N)
        past_run_r |-> DATA_IRQ_REQ == ($past(FIFO_LEVEL) > $past(irq_thr_r));
    endproperty
    a_data_req: assert property (p_data_req) // RQ5
        else $error("data interrupt request wrong");

    property p_dma_req;
        @(posedge CLK) disable iff (!RST_N)
        past_run_r |-> DMA_REQ == ($past(FIFO_LEVEL) > $past(dma_thr_r));
    endproperty
    a_dma_req: assert property (p_dma_req) // RQ6
        else $error("dma request wrong");

    property p_arm;
        @(posedge CLK) disable iff (!RST_N)
        (wr_ctrl ##1 (RX_STATUS == 8'hFF))
        |=> STATUS_IRQ_REQ == |($past(WDATA, 2) & 16'h00F6);
    endproperty
    a_arm: assert property (p_arm) // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12
        else $error("arm bit does not gate status");

    property p_word;
        @(posedge CLK) disable iff (!RST_N)
        wr_ctrl |=> TWO_CHAR_STATUS == $past(WDATA[3]);
    endproperty
    a_word: assert property (p_word) // RQ13
        else $error("two character select wrong");

    property p_tc0;
        @(posedge CLK) disable iff (!RST_N)
        TC0_RD |=> TC0_RDATA == ($past(low_r[0]) ? $past(TC0_COUNT) : $past(TC0_VALUE));
    endproperty
    a_tc0: assert property (p_tc0) // RQ14
        else $error("time constant read wrong");

    property p_view;
        @(posedge CLK) disable iff (!RST_N)
        (wr_cmd && cmd_in == CMD_IRQ_THR) ##1 (RD && hit(ADDR, OFS_CTRL))
        |=> RDATA[15:8] == $past(irq_thr_r);
    endproperty
    a_view: assert property (p_view) // RQ15
        else $error("view does not follow command");

    property p_status;
        @(posedge CLK) disable iff (!RST_N)
        past_run_r |-> STATUS_IRQ_REQ == |($past(RX_STATUS) & $past(low_r) & 8'hF6);
    endproperty
    a_status: assert property (p_status) // RQ16
        else $error("status request without flag and arm");

endmodule
`default_nettype wire

// ### verif/testbench.sv
// Purpose: self-checking bench of the receive interrupt control register
// Assumes: one 125 MHz clock, synchronous active-low reset held 20 cycles
// Notes: random stimulus from a fixed seed, corner cases mixed in
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rx_irq_pkg::*;

    // ==========================================================
    // clock, reset and design ports
    logic clk;
    logic rst_n;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr_s;
    logic rd_s;
    logic [15:0] rdata;
    logic [7:0] rx_status;
    logic [7:0] fifo;
    logic [15:0] tc_val;
    logic [15:0] tc_cnt;
    logic tc_rd;
    logic [15:0] tc_rdata;
    logic stat_req;
    logic data_req;
    logic dma_req;
    logic two_char;
    slot_cfg_t slot_cfg;
    logic tsa_en;
    logic irq;
    int failures = 0;
    int checked = 0;

    rx_irq_ctrl_top u_rx_irq_ctrl_top (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .RX_STATUS(rx_status), .FIFO_LEVEL(fifo), .TC0_VALUE(tc_val),
        .TC0_COUNT(tc_cnt), .TC0_RD(tc_rd), .TC0_RDATA(tc_rdata), .STATUS_IRQ_REQ(stat_req),
        .DATA_IRQ_REQ(data_req), .DMA_REQ(dma_req), .TWO_CHAR_STATUS(two_char),
        .SLOT_CFG(slot_cfg), .TSA_ENABLE(tsa_en), .IRQ(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function automatic logic exp_stat(input logic [7:0] st, input logic [7:0] arm);
        return |(st & arm & ARM_BITS);
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    // write then read with no idle cycle between the strobes
    task automatic wr_then_rd(input logic [7:0] wa, input logic [15:0] wd, input logic [7:0] ra,
        input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= wa;
        wdata <= wd;
        wr_s <= 1'b1;
        @(posedge clk);
        addr <= ra;
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    // requests are registered, so allow two edges after the cause
    task automatic put_in(input logic [7:0] st, input logic [7:0] lvl);
        @(posedge clk);
        rx_status <= st;
        fifo <= lvl;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // watchdog, generous against some 200 cycles of tests
    initial
    begin
        #(8 * 20000);
        failures++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        logic [7:0] lo;
        logic [7:0] st;
        logic [7:0] thr;
        logic [6:0] num;
        logic [2:0] dly;
        logic [3:0] cnt;
        logic [3:0] codes [2];
        logic [3:0] counts [4];
        int bits [6];
        void'($urandom(32'h1690));
        bits = '{7, 6, 5, 4, 2, 1};
        codes = '{CMD_IRQ_THR, CMD_DMA_THR};
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        wr_s = 1'b0;
        rd_s = 1'b0;
        rx_status = 8'h00;
        fifo = 8'h00;
        tc_val = 16'h0000;
        tc_cnt = 16'h0000;
        tc_rd = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("slot cfg at reset", 16'h0000, {2'b00, slot_cfg});
        chk("tsa enable at reset", 16'h0000, {15'h0000, tsa_en});
        lo = 8'h00;
        // fill view after reset, upper byte read-only
        put_in(8'h00, 8'($urandom));
        reg_rd(OFS_CTRL, {fifo, 8'h00}, "fill view");
        reg_wr(OFS_CTRL, {~fifo, lo});
        reg_rd(OFS_CTRL, {fifo, lo}, "fill view after write");
        reg_rd(8'h10, 16'h0000, "unmapped read");
        // low byte read/write, queued status select
        repeat (4)
        begin
            lo = 8'($urandom);
            reg_wr(OFS_CTRL, {8'h00, lo});
            reg_rd(OFS_CTRL, {fifo, lo}, "low byte");
            chk("two char status", {15'h0000, lo[POS_WORD]}, {15'h0000, two_char});
        end
        // one arm bit at a time against random status flags
        foreach (bits[i])
        begin
            lo = 8'h01 << bits[i];
            reg_wr(OFS_CTRL, {8'h00, lo});
            for (int k = 0; k < 2; k++)
            begin
                st = 8'($urandom);
                st = (k == 0) ? (st | lo) : (st & ~lo);
                put_in(st, fifo);
                chk("status request", {15'h0000, exp_stat(st, lo)}, {15'h0000, stat_req});
            end
        end
        // all flags up before the arm write lands
        put_in(8'hFF, fifo);
        lo = 8'($urandom);
        reg_wr(OFS_CTRL, {8'h00, lo});
        @(posedge clk);
        #1;
        chk("status all flags", {15'h0000, exp_stat(8'hFF, lo)}, {15'h0000, stat_req});
        // event status, mask and interrupt line
        put_in(8'h00, fifo);
        reg_rd(OFS_EVT, 16'({fifo != 8'h00, fifo != 8'h00, 1'b1}), "event flush");
        lo = 8'h02;
        reg_wr(OFS_CTRL, {8'h00, lo});
        reg_wr(OFS_MASK, 16'h0001);
        reg_rd(OFS_MASK, 16'h0001, "event mask");
        put_in(8'h02, fifo);
        @(posedge clk);
        #1;
        chk("irq on armed status", 16'h0001, {15'h0000, irq});
        reg_rd(OFS_EVT, 16'h0001, "event status");
        chk("irq after clear", 16'h0000, {15'h0000, irq});
        reg_wr(OFS_MASK, 16'h0000);
        put_in(8'h00, fifo);
        put_in(8'h02, fifo);
        @(posedge clk);
        #1;
        chk("irq while masked", 16'h0000, {15'h0000, irq});
        reg_rd(OFS_EVT, 16'h0001, "masked event");
        // read clear in the very cycle the event lands
        put_in(8'h00, fifo);
        @(posedge clk);
        rx_status <= 8'h02;
        @(posedge clk);
        addr <= OFS_EVT;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk("event before set", 16'h0000, rdata);
        reg_rd(OFS_EVT, 16'h0001, "set wins over clear");
        // slot view: number, then delay and count
        reg_wr(OFS_CMD, {CMD_SLOT, 12'h000});
        reg_rd(OFS_CMD, {CMD_SLOT, 12'h000}, "select code");
        num = 7'($urandom);
        wr_then_rd(OFS_CTRL, {num, 1'b0, lo}, OFS_CTRL, {num, 1'b0, lo}, "slot number");
        counts = '{4'h0, 4'h1, 4'hF, 4'($urandom)};
        foreach (counts[i])
        begin
            cnt = counts[i];
            dly = 3'($urandom);
            reg_wr(OFS_CTRL, {dly, cnt, 1'b1, lo});
            chk("slot cfg", {2'b00, num, dly, cnt}, {2'b00, slot_cfg});
            chk("tsa enable", {15'h0000, cnt != 4'h0}, {15'h0000, tsa_en});
            reg_rd(OFS_CTRL, {num, 1'b0, lo}, "delay write-only");
        end
        // threshold views, request when the level is strictly above
        foreach (codes[i])
        begin
            wr_then_rd(OFS_CMD, {codes[i], 12'h000}, OFS_CTRL, {THR_RST, lo}, "threshold at reset");
            thr = 8'($urandom) & 8'hFE;
            reg_wr(OFS_CTRL, {thr, lo});
            reg_rd(OFS_CTRL, {thr, lo}, "threshold");
            for (int k = 0; k < 3; k++)
            begin
                put_in(8'h00, (k == 2) ? 8'h00 : thr + 8'(k));
                chk("level request", {15'h0000, fifo > thr},
                    {15'h0000, (i == 0) ? data_req : dma_req});
            end
            reg_wr(OFS_CMD, 16'h9000);
            reg_rd(OFS_CTRL, {thr, lo}, "view kept");
        end
        reg_wr(OFS_CMD, {CMD_FILL, 12'h000});
        reg_rd(OFS_CTRL, {fifo, lo}, "back to fill");
        // time constant read source
        for (int k = 0; k < 2; k++)
        begin
            lo[POS_TC_SEL] = k[0];
            reg_wr(OFS_CTRL, {8'h00, lo});
            @(posedge clk);
            tc_val <= 16'($urandom);
            tc_cnt <= 16'($urandom);
            tc_rd <= 1'b1;
            @(posedge clk);
            tc_rd <= 1'b0;
            #1;
            chk("time constant read", k[0] ? tc_cnt : tc_val, tc_rdata);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
